/* File: hw/hiev_map.vh */
// Register offsets, bit positions and reset values of the interrupt event register block
`ifndef HIEV_MAP_VH
`define HIEV_MAP_VH

`define HIEV_AW              4
`define HIEV_DW              32
`define HIEV_ADDR_EVT_SET    4'h0
`define HIEV_ADDR_EVT_CLR    4'h1
`define HIEV_ADDR_MASK_SET   4'h2
`define HIEV_ADDR_MASK_CLR   4'h3
`define HIEV_ADDR_ISO_TX_SET 4'h4
`define HIEV_ADDR_ISO_TX_CLR 4'h5
`define HIEV_ADDR_ISO_TX_MSK 4'h6
`define HIEV_ADDR_ISO_RX_SET 4'h7
`define HIEV_ADDR_ISO_RX_CLR 4'h8
`define HIEV_ADDR_ISO_RX_MSK 4'h9
`define HIEV_ADDR_STATUS     4'ha

`define HIEV_BIT_ISO_TX      6
`define HIEV_BIT_ISO_RX      7
`define HIEV_BIT_SELF_ID     16
`define HIEV_BIT_BUS_RESET   17
`define HIEV_BIT_GLOBAL_EN   31

// Latched event bits: 0-5, 8, 9, 16, 17
`define HIEV_LATCH_MASK      32'h0003_033f
// Mask bits that exist: events 0-9, 16, 17 and the global enable
`define HIEV_MASK_VALID      32'h8003_03ff
`define HIEV_ZERO            32'h0000_0000
`define HIEV_EVT_RESET       32'h0000_0000
`define HIEV_MASK_RESET      32'h0000_0000
// Event positions that may raise the interrupt; bit 31 is the enable itself
`define HIEV_IRQ_SRC_MASK    32'h7fff_ffff

`endif

/* File: hw/hiev_event_reg.v */
// Primary interrupt event register with set and clear aliases and its mask
`timescale 1ns/10ps
`include "hiev_map.vh"

// Summary of operation
// - A rising edge on an event source sets its event bit.
// - Writing one at the set alias sets that event bit.
// - Writing one at the clear alias clears that event bit.
// - Reading the set alias returns all event bits unmasked.
// - Reading the clear alias returns event bits ANDed with mask bits.
// - Event bits cleared to zero at reset; software clears before use.
// - Bit 0: request transmit last-output done, when descriptor asks.
// - Bit 1: response transmit last-output done, when descriptor asks.
// - Bit 2: receive request buffer descriptor done, when asked.
// - Bit 3: receive response buffer descriptor done, when asked.
// - Bit 4: per received request packet, after status written back.
// - Bit 5: per received response packet, after status written back.
// - Bit 6: unlatched OR of iso transmit events ANDed with mask.
// - Bit 7: unlatched OR of iso receive events ANDed with mask.
// - Bit 8: host bus error writing acknowledged posted write data.
// - Bit 9: lock response failed after all retries.
// - Bit 16: self-identification stream complete.
// - Self-id-complete clears in the cycle bus reset event sets.
// - Bit 17: physical layer entered bus reset.
// - Writing zero at either alias leaves a bit unchanged.
// - Interrupt asserted while any set event bit is also masked in.
// - Global enable bit 31 low blocks interrupt; clear-alias reads unaffected.
// - Software cannot clear bus reset event during self-id phase.

module hiev_event_reg #(
    parameter ISO_TX_N = 32,
    parameter ISO_RX_N = 32
) (
    input  wire                   clk,
    input  wire                   rst,
    input  wire                   ce,
    input  wire [`HIEV_AW-1:0]    addr,
    input  wire [`HIEV_DW-1:0]    wdata,
    input  wire                   wr,
    input  wire                   rd,
    output reg  [`HIEV_DW-1:0]    rdata,
    input  wire                   async_req_tx_done,
    input  wire                   async_rsp_tx_done,
    input  wire                   rx_req_buffer_done,
    input  wire                   rx_rsp_buffer_done,
    input  wire                   rx_req_packet_done,
    input  wire                   rx_rsp_packet_done,
    input  wire                   posted_write_fault,
    input  wire                   lock_response_fault,
    input  wire                   self_ident_done,
    input  wire                   bus_reset_seen,
    input  wire                   self_id_phase,
    input  wire [ISO_TX_N-1:0]    iso_tx_src,
    input  wire [ISO_RX_N-1:0]    iso_rx_src,
    output reg                    irq
);

    reg  [`HIEV_DW-1:0] interrupt_event_flags_r;
    reg  [`HIEV_DW-1:0] interrupt_event_flags_nxt;
    reg  [`HIEV_DW-1:0] interrupt_mask_bits_r;
    reg  [`HIEV_DW-1:0] interrupt_mask_bits_nxt;
    reg  [`HIEV_DW-1:0] src_prev_r;
    reg  [ISO_TX_N-1:0] iso_tx_event_flags_r;
    reg  [ISO_TX_N-1:0] iso_tx_event_mask_r;
    reg  [ISO_RX_N-1:0] iso_rx_event_flags_r;
    reg  [ISO_RX_N-1:0] iso_rx_event_mask_r;
    reg  [ISO_TX_N-1:0] iso_tx_prev_r;
    reg  [ISO_RX_N-1:0] iso_rx_prev_r;
    reg  [`HIEV_DW-1:0] rdata_nxt;
    reg  [`HIEV_DW-1:0] set_bits;
    reg  [`HIEV_DW-1:0] clr_bits;
    wire [`HIEV_DW-1:0] src_now;
    wire [`HIEV_DW-1:0] src_rise;
    wire [ISO_TX_N-1:0] iso_tx_rise;
    wire [ISO_RX_N-1:0] iso_rx_rise;
    wire                iso_tx_summary;
    wire                iso_rx_summary;
    wire [`HIEV_DW-1:0] event_view;
    wire                wr_evt_set;
    wire                wr_evt_clr;
    wire [ISO_TX_N-1:0] iso_tx_set_bits;
    wire [ISO_TX_N-1:0] iso_tx_clr_bits;
    wire [ISO_RX_N-1:0] iso_rx_set_bits;
    wire [ISO_RX_N-1:0] iso_rx_clr_bits;

    // Each source sits at its event bit position
    assign src_now = {14'h0000,
                      bus_reset_seen,
                      self_ident_done,
                      6'h00,
                      lock_response_fault,
                      posted_write_fault,
                      2'h0,
                      rx_rsp_packet_done,
                      rx_req_packet_done,
                      rx_rsp_buffer_done,
                      rx_req_buffer_done,
                      async_rsp_tx_done,
                      async_req_tx_done};

    // Edge detect, so a source held high sets the bit only once
    assign src_rise = src_now & ~src_prev_r & `HIEV_LATCH_MASK;

    assign iso_tx_rise = iso_tx_src & ~iso_tx_prev_r;
    assign iso_rx_rise = iso_rx_src & ~iso_rx_prev_r;

    assign iso_tx_summary = |(iso_tx_event_flags_r & iso_tx_event_mask_r);
    assign iso_rx_summary = |(iso_rx_event_flags_r & iso_rx_event_mask_r);

    // Summary bits are live, never stored
    assign event_view = (interrupt_event_flags_r & `HIEV_LATCH_MASK)
                      | ({{(`HIEV_DW-1){1'b0}}, iso_tx_summary} << `HIEV_BIT_ISO_TX)
                      | ({{(`HIEV_DW-1){1'b0}}, iso_rx_summary} << `HIEV_BIT_ISO_RX);

    assign wr_evt_set = wr && (addr == `HIEV_ADDR_EVT_SET);
    assign wr_evt_clr = wr && (addr == `HIEV_ADDR_EVT_CLR);

    assign iso_tx_set_bits = (wr && (addr == `HIEV_ADDR_ISO_TX_SET)) ? wdata[ISO_TX_N-1:0]
                                                                   : {ISO_TX_N{1'b0}};
    assign iso_tx_clr_bits = (wr && (addr == `HIEV_ADDR_ISO_TX_CLR)) ? wdata[ISO_TX_N-1:0]
                                                                   : {ISO_TX_N{1'b0}};
    assign iso_rx_set_bits = (wr && (addr == `HIEV_ADDR_ISO_RX_SET)) ? wdata[ISO_RX_N-1:0]
                                                                   : {ISO_RX_N{1'b0}};
    assign iso_rx_clr_bits = (wr && (addr == `HIEV_ADDR_ISO_RX_CLR)) ? wdata[ISO_RX_N-1:0]
                                                                   : {ISO_RX_N{1'b0}};

    always @* begin
        set_bits = src_rise;
        if (wr_evt_set) begin
            set_bits = set_bits | (wdata & `HIEV_LATCH_MASK);
        end
        clr_bits = `HIEV_ZERO;
        if (wr_evt_clr) begin
            clr_bits = wdata & `HIEV_LATCH_MASK;
        end
        if (self_id_phase) begin
            clr_bits[`HIEV_BIT_BUS_RESET] = 1'b0;
        end
        // A new event beats a simultaneous software clear
        interrupt_event_flags_nxt = (interrupt_event_flags_r & ~clr_bits) | set_bits;
        // Bus reset setting wipes self-id complete, even one arriving now
        if (set_bits[`HIEV_BIT_BUS_RESET] && !interrupt_event_flags_r[`HIEV_BIT_BUS_RESET]) begin
            interrupt_event_flags_nxt[`HIEV_BIT_SELF_ID] = 1'b0;
        end
    end

    always @* begin
        interrupt_mask_bits_nxt = interrupt_mask_bits_r;
        if (wr && (addr == `HIEV_ADDR_MASK_SET)) begin
            interrupt_mask_bits_nxt = interrupt_mask_bits_r | (wdata & `HIEV_MASK_VALID);
        end
        if (wr && (addr == `HIEV_ADDR_MASK_CLR)) begin
            interrupt_mask_bits_nxt = interrupt_mask_bits_r & ~(wdata & `HIEV_MASK_VALID);
        end
    end

    always @* begin
        rdata_nxt = `HIEV_ZERO;
        case (addr)
            `HIEV_ADDR_EVT_SET:    rdata_nxt = event_view;
            `HIEV_ADDR_EVT_CLR:    rdata_nxt = event_view & interrupt_mask_bits_r;
            `HIEV_ADDR_MASK_SET,
            `HIEV_ADDR_MASK_CLR:   rdata_nxt = interrupt_mask_bits_r;
            `HIEV_ADDR_ISO_TX_SET: rdata_nxt[ISO_TX_N-1:0] = iso_tx_event_flags_r;
            `HIEV_ADDR_ISO_TX_CLR: rdata_nxt[ISO_TX_N-1:0] = iso_tx_event_flags_r
                                                           & iso_tx_event_mask_r;
            `HIEV_ADDR_ISO_TX_MSK: rdata_nxt[ISO_TX_N-1:0] = iso_tx_event_mask_r;
            `HIEV_ADDR_ISO_RX_SET: rdata_nxt[ISO_RX_N-1:0] = iso_rx_event_flags_r;
            `HIEV_ADDR_ISO_RX_CLR: rdata_nxt[ISO_RX_N-1:0] = iso_rx_event_flags_r
                                                           & iso_rx_event_mask_r;
            `HIEV_ADDR_ISO_RX_MSK: rdata_nxt[ISO_RX_N-1:0] = iso_rx_event_mask_r;
            `HIEV_ADDR_STATUS:     rdata_nxt[0] = irq;
            default:               rdata_nxt = `HIEV_ZERO;
        endcase
        if (!rd) begin
            rdata_nxt = `HIEV_ZERO;
        end
    end

    // Event flags are cleared at reset although software must not rely on it
    always @(posedge clk) begin
        if (rst) begin
            interrupt_event_flags_r <= `HIEV_EVT_RESET;
            interrupt_mask_bits_r   <= `HIEV_MASK_RESET;
            src_prev_r              <= `HIEV_ZERO;
            iso_tx_event_flags_r    <= {ISO_TX_N{1'b0}};
            iso_tx_event_mask_r     <= {ISO_TX_N{1'b0}};
            iso_rx_event_flags_r    <= {ISO_RX_N{1'b0}};
            iso_rx_event_mask_r     <= {ISO_RX_N{1'b0}};
            iso_tx_prev_r           <= {ISO_TX_N{1'b0}};
            iso_rx_prev_r           <= {ISO_RX_N{1'b0}};
            rdata                   <= `HIEV_ZERO;
            irq                     <= 1'b0;
        end else if (ce) begin
            interrupt_event_flags_r <= interrupt_event_flags_nxt;
            interrupt_mask_bits_r   <= interrupt_mask_bits_nxt;
            src_prev_r              <= src_now;
            iso_tx_prev_r           <= iso_tx_src;
            iso_rx_prev_r           <= iso_rx_src;
            if (wr && (addr == `HIEV_ADDR_ISO_TX_MSK)) begin
                iso_tx_event_mask_r <= wdata[ISO_TX_N-1:0];
            end
            if (wr && (addr == `HIEV_ADDR_ISO_RX_MSK)) begin
                iso_rx_event_mask_r <= wdata[ISO_RX_N-1:0];
            end
            // Same set-over-clear discipline for the secondary flags
            iso_tx_event_flags_r <= (iso_tx_event_flags_r & ~iso_tx_clr_bits)
                                  | iso_tx_rise
                                  | iso_tx_set_bits;
            iso_rx_event_flags_r <= (iso_rx_event_flags_r & ~iso_rx_clr_bits)
                                  | iso_rx_rise
                                  | iso_rx_set_bits;
            rdata <= rdata_nxt;
            // Registered, so it follows the flags by one cycle
            irq <= interrupt_mask_bits_r[`HIEV_BIT_GLOBAL_EN]
                && (|(event_view & interrupt_mask_bits_r & `HIEV_IRQ_SRC_MASK));
        end
    end

endmodule

/* File: test/hiev_event_reg_monitor.sv */
// Port-level assertions for the interrupt event register
`timescale 1ns/10ps
module hiev_event_reg_monitor (
    input wire        clk,
    input wire        rst,
    input wire        ce,
    input wire [3:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [31:0] rdata,
    input wire        irq,
    input wire        bus_reset_seen,
    input wire        self_id_phase
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Bit 16 left out: a bus reset event may clear it meanwhile
    localparam [31:0] KEEP = 32'h0002_033f;
    a_rd_idle_zero: assert property (ce && !rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_rsv_read_zero: assert property (rd && addr < 4'h2 |=> (rdata & 32'hfffc_fc00) == 0)
        else $error("reserved event bit read as one");
    a_unmapped_zero: assert property (rd && addr > 4'ha |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_irq_has_cause: assert property (rd && addr == 4'h1 |=> !irq || rdata != 0)
        else $error("interrupt with no masked event");
    a_set_reads_back: assert property (wr && addr == 4'h0 ##1 rd && addr == 4'h0
        |=> (rdata & $past(wdata, 2) & KEEP) == ($past(wdata, 2) & KEEP))
        else $error("set alias write not seen");
    a_bus_rst_event: assert property ($rose(bus_reset_seen) && !wr ##1 rd && addr == 4'h0
        |=> rdata[17] && !rdata[16])
        else $error("bus reset event wrong");
    a_zero_bit_keeps: assert property (rd && addr == 4'h0 ##1 wr && addr == 4'h1
        ##1 rd && addr == 4'h0 |=> ($past(rdata, 2) & ~$past(wdata, 2) & ~rdata & KEEP) == 0)
        else $error("zero write changed an event bit");
    a_sid_no_clear: assert property (rd && addr == 4'h0 ##1 rdata[17] && wr && addr == 4'h1
        && wdata[17] && self_id_phase ##1 rd && addr == 4'h0 |=> rdata[17])
        else $error("bus reset event cleared during self-id");
endmodule

/* File: test/hiev_event_reg_tb.sv */
// Register-bus test of the interrupt event register
`timescale 1ns/10ps
module hiev_event_reg_tb;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         ce = 1'b1;
    reg  [3:0]  addr = 4'h0;
    reg  [31:0] wdata = 32'h0;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg  [9:0]  ev = 10'h0;
    reg         sid = 1'b0;
    reg  [31:0] itx = 32'h0;
    reg  [31:0] irx = 32'h0;
    reg  [31:0] exp_ev;
    wire [31:0] rdata;
    wire        irq;
    integer     failures = 0;
    integer     n_compared = 0;
    integer     i;
    always #2 clk = ~clk;
    hiev_event_reg dut_u (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .async_req_tx_done(ev[0]), .async_rsp_tx_done(ev[1]),
        .rx_req_buffer_done(ev[2]), .rx_rsp_buffer_done(ev[3]), .rx_req_packet_done(ev[4]),
        .rx_rsp_packet_done(ev[5]), .posted_write_fault(ev[6]), .lock_response_fault(ev[7]),
        .self_ident_done(ev[8]), .bus_reset_seen(ev[9]), .self_id_phase(sid),
        .iso_tx_src(itx), .iso_rx_src(irx), .irq(irq));
    task chk(input [31:0] got, input [31:0] want);
        begin
            n_compared = n_compared + 1;
            if (got !== want) begin
                failures = failures + 1;
                $display("Error at %0t: got %h, expected %h", $time, got, want);
            end
        end
    endtask
    // Strobes stay up until the next call, so calls run back to back
    task op(input w, input r, input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            wr <= w;
            rd <= r;
            addr <= a;
            wdata <= d;
        end
    endtask
    task rd_x(input [3:0] a, input [31:0] want);
        begin
            op(1'b0, 1'b1, a, 32'h0);
            op(1'b0, 1'b0, a, 32'h0);
            #1 chk(rdata, want);
        end
    endtask
    task rwr(input [31:0] w, input [31:0] old, input [31:0] want);
        begin
            op(1'b0, 1'b1, 4'h0, 32'h0);
            op(1'b1, 1'b0, 4'h1, w);
            #1 chk(rdata, old);
            rd_x(4'h0, want);
        end
    endtask
    task report_and_stop;
        begin
            if (failures == 0 && n_compared > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_x(4'h0, 32'h0);
        op(1'b1, 1'b0, 4'h0, 32'hfffc_ffff);
        rd_x(4'h0, 32'h0000_033f);
        op(1'b1, 1'b0, 4'h0, 32'h0001_0000);
        rd_x(4'h0, 32'h0001_033f);
        op(1'b1, 1'b0, 4'h2, 32'hffff_ffff);
        rd_x(4'h2, 32'h8003_03ff);
        rd_x(4'h1, 32'h0001_033f);
        chk(irq, 32'h1);
        rd_x(4'ha, 32'h1);
        rwr(32'h0000_0005, 32'h0001_033f, 32'h0001_033a);
        op(1'b1, 1'b0, 4'h3, 32'h8000_0000);
        rd_x(4'h1, 32'h0001_033a);
        chk(irq, 32'h0);
        op(1'b1, 1'b0, 4'h2, 32'h8000_0000);
        op(1'b1, 1'b0, 4'h1, 32'hffff_ffff);
        rd_x(4'h0, 32'h0);
        chk(irq, 32'h0);
        exp_ev = 32'h0;
        for (i = 0; i < 10; i = i + 1) begin
            exp_ev = exp_ev | (32'h1 << (i < 6 ? i : (i < 8 ? i + 2 : i + 8)));
            if (i == 9)
                exp_ev[16] = 1'b0;
            @(posedge clk) ev <= 10'h1 << i;
            op(1'b0, 1'b1, 4'h0, 32'h0);
            ev <= 10'h0;
            op(1'b0, 1'b0, 4'h0, 32'h0);
            #1 chk(rdata, exp_ev);
        end
        @(posedge clk) sid <= 1'b1;
        rwr(32'h0002_0000, exp_ev, exp_ev);
        @(posedge clk) sid <= 1'b0;
        rwr(32'h0002_0000, exp_ev, 32'h0000_033f);
        op(1'b1, 1'b0, 4'h1, 32'hffff_ffff);
        op(1'b1, 1'b0, 4'h6, 32'hffff_ffff);
        op(1'b1, 1'b0, 4'h9, 32'hffff_ffff);
        op(1'b1, 1'b0, 4'h7, 32'h1);
        itx <= 32'h8;
        op(1'b1, 1'b0, 4'h4, 32'h10);
        rd_x(4'h0, 32'h0000_00c0);
        rd_x(4'h4, 32'h0000_0018);
        rd_x(4'h8, 32'h0000_0001);
        op(1'b1, 1'b0, 4'h5, 32'hffff_ffff);
        op(1'b1, 1'b0, 4'h8, 32'hffff_ffff);
        rd_x(4'h0, 32'h0);
        op(1'b1, 1'b0, 4'hf, 32'hffff_ffff);
        rd_x(4'hf, 32'h0);
        // Event rising in the same cycle as a clear-all: the set wins
        op(1'b1, 1'b0, 4'h1, 32'hffff_ffff);
        ev <= 10'h001;
        rd_x(4'h0, 32'h0000_0001);
        // Clock enable low: the clear must not land
        op(1'b1, 1'b0, 4'h1, 32'hffff_ffff);
        ce <= 1'b0;
        op(1'b0, 1'b0, 4'h0, 32'h0);
        ce <= 1'b1;
        rd_x(4'h0, 32'h0000_0001);
        // Self-id done and bus reset rising together: only bus reset remains
        op(1'b1, 1'b0, 4'h1, 32'hffff_ffff);
        ev <= 10'h300;
        rd_x(4'h0, 32'h0002_0000);
        report_and_stop;
    end
    // About fifty times the length of the sequence above
    initial begin
        #20000;
        failures = failures + 1;
        report_and_stop;
    end
endmodule
bind hiev_event_reg hiev_event_reg_monitor mon_u (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .bus_reset_seen(bus_reset_seen), .self_id_phase(self_id_phase));
